// ### design/edge_sync3.sv
`timescale 1ns/1ns
`default_nettype none
// Three-stage synchroniser; level moves once stages two and three agree
module edge_sync3 (
  input wire logic clk,
  input wire logic reset,
  input wire logic async_in,
  output logic level,
  output logic rise
);
  logic s1_reg, s2_reg, s3_reg, level_reg;
  logic level_next;

  // New level only when the late stages agree
  always_comb begin
    level_next = level_reg;
    if (s2_reg == s3_reg) begin
      level_next = s3_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      level_reg <= 1'b0;
    end else begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      level_reg <= level_next;
    end
  end

  assign level = level_reg;
  assign rise = level_next & ~level_reg;
endmodule // edge_sync3
`default_nettype wire

// ### design/lock_window_meas.sv
`timescale 1ns/1ns
`default_nettype none
// Judges each reference edge: did the VCO edge land in the window around it
module lock_window_meas
  import pll_lock_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic enable,
  input wire logic ref_rise,
  input wire logic vco_rise,
  input wire window_type window,
  output verdict_type verdict
);
  win_state_type state_reg, state_next;
  logic [13:0] age_reg, age_next;
  logic [13:0] late_reg, late_next;
  verdict_type verdict_reg, verdict_next;

  // Early part looks back on VCO age, late part waits forward
  always_comb begin
    state_next = state_reg;
    late_next = late_reg;
    verdict_next = '0;
    age_next = (age_reg == 14'h3FFF) ? age_reg : age_reg + 14'h0001;
    if (vco_rise) begin
      age_next = 14'h0000;
    end
    if (!enable) begin
      state_next = WAIT_REF;
      age_next = 14'h3FFF;
    end else begin
      case (state_reg)
        WAIT_REF: begin
          if (ref_rise) begin
            if (vco_rise || (age_reg < window.early_cycles)) begin
              verdict_next.hit = 1'b1;
              age_next = 14'h3FFF;
            end else if (window.late_cycles == 14'h0000) begin
              verdict_next.miss = 1'b1;
            end else begin
              state_next = LATE_OPEN;
              late_next = window.late_cycles;
            end
          end
        end
        LATE_OPEN: begin
          if (vco_rise) begin
            verdict_next.hit = 1'b1;
            age_next = 14'h3FFF;
            state_next = WAIT_REF;
          end else if (late_reg == 14'h0001 || ref_rise) begin
            verdict_next.miss = 1'b1;
            state_next = WAIT_REF;
          end else begin
            late_next = late_reg - 14'h0001;
          end
        end
        default: state_next = WAIT_REF;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= WAIT_REF;
      age_reg <= 14'h3FFF;
      late_reg <= 14'h0000;
      verdict_reg <= '0;
    end else begin
      state_reg <= state_next;
      age_reg <= age_next;
      late_reg <= late_next;
      verdict_reg <= verdict_next;
    end
  end

  assign verdict = verdict_reg;
endmodule // lock_window_meas
`default_nettype wire

// ### design/pll_lock_cfg.svh
`ifndef PLL_LOCK_CFG_SVH
`define PLL_LOCK_CFG_SVH

// Clock and window timing
`define CLK_PERIOD_NS 20
`define ANALOG_WIN_NS 10
`define ANALOG_WIN_CYC (((`ANALOG_WIN_NS) + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS))

// Register byte offsets
`define OFS_CTRL 8'h00
`define OFS_WINDOW 8'h04
`define OFS_THRESH 8'h08
`define OFS_CSP 8'h0C
`define OFS_PUMP 8'h10
`define OFS_STATUS 8'h14
`define OFS_IRQ_STAT 8'h18
`define OFS_IRQ_MASK 8'h1C

// Reset values
`define RST_CTRL 6'h00
`define RST_RING_CFG 4'h0
`define RST_DURATION 8'h01
`define RST_THRESH 16'h03E8
`define RST_CORR 8'h04
`define RST_PUMP_GAIN 3'h2
`define RST_PUMP_TRIM 4'h0

// Field positions
`define WIN_DUR_LSB 8
`define PUMP_DN_GAIN_LSB 4
`define PUMP_UP_TRIM_LSB 8
`define PUMP_DN_TRIM_LSB 12
`define STAT_COUNT_LSB 16

// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ### design/pll_lock_detect_and_pump_ctrl.sv
// How it works
// - Lock detection runs only while the lock detect enable bit is set.
// - With the ring source cleared the window is a fixed 10 ns one-shot around the reference; the code rounds it up to one 20 ns clock cycle.
// - With the ring source set the window is duration times ring period, the period set apart.
// - The lock flag rises after the threshold count of consecutive in-window VCO edges.
// - One out-of-window VCO edge drops the flag at once until the threshold is met again.
// - The lock flag is readable as a read-only status bit.
// - With the pin enable set the shared pin carries the lock flag, serial data during reads.
// - Asymmetry with the delay select set moves the window after the reference.
// - Asymmetry with the delay select cleared moves the window ahead of the reference.
// - Cycle slip prevention holds pump gain at maximum until the frequencies match.
// - A correction magnitude field sets how sensitive slip prevention is.
// - Three-bit up and down gain selects each drive 500, 1000 and 500 uA sources; 010 is 1 mA.
// - Four-bit binary trims for each pump, 7 uA steps up to 105 uA.
//
// Chosen here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "pll_lock_cfg.svh"
module pll_lock_detect_and_pump_ctrl
  import pll_lock_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire logic REF_DIV_IN,
  input wire logic VCO_DIV_IN,
  input wire logic SERIAL_READ_ACTIVE,
  input wire logic SERIAL_READ_DATA,
  output logic LOCK_OR_SERIAL_OUT_PIN,
  output logic LOCK_OR_SERIAL_OUT_OE_N,
  output logic LOCK_FLAG,
  output logic CSP_GAIN_HOLD,
  output logic [2:0] PUMP_UP_SOURCES,
  output logic [2:0] PUMP_DOWN_SOURCES,
  output logic [3:0] PUMP_UP_TRIM_OUT,
  output logic [3:0] PUMP_DOWN_TRIM_OUT,
  output logic IRQ,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);
  // Merge write data under byte strobes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Window cycles from source, ring period and duration
  function automatic logic [13:0] win_cycles(input ctrl_type c, input logic [3:0] ring,
                                            input logic [7:0] dur);
    logic [13:0] w;
    w = 14'(`ANALOG_WIN_CYC);
    if (c.window_from_ring) begin
      w = 14'(dur) * (14'(ring) + 14'h0001);
      if (w == 14'h0000) begin
        w = 14'h0001;
      end
    end
    return w;
  endfunction

  // Configuration and status registers
  ctrl_type ctrl_reg, ctrl_next;
  logic [3:0] ring_cfg_reg, ring_cfg_next;
  logic [7:0] duration_reg, duration_next;
  logic [15:0] thresh_reg, thresh_next;
  logic [7:0] corr_reg, corr_next;
  logic [2:0] up_gain_reg, up_gain_next, dn_gain_reg, dn_gain_next;
  logic [3:0] up_trim_reg, up_trim_next, dn_trim_reg, dn_trim_next;
  logic [2:0] irq_stat_reg, irq_stat_next, irq_mask_reg, irq_mask_next;
  // Bus handshake state
  logic aw_have_reg, aw_have_next, w_have_reg, w_have_next;
  logic [7:0] awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  // Lock, slip and output state
  logic [15:0] hits_reg, hits_next;
  logic lock_reg, lock_next;
  logic [7:0] match_reg, match_next;
  logic [1:0] vco_per_ref_reg, vco_per_ref_next;
  logic hold_reg, hold_next;
  logic [2:0] up_src_reg, up_src_next, dn_src_reg, dn_src_next;
  logic pin_reg, pin_next, oe_n_reg, oe_n_next;

  logic ref_rise, vco_rise;
  logic do_write, do_read;
  logic [2:0] events;
  logic [13:0] w_total;
  window_type window;
  verdict_type verdict;

  edge_sync3 ref_sync (
    .clk(SYS_CLK), .reset(RESET), .async_in(REF_DIV_IN), .level(), .rise(ref_rise)
  );
  edge_sync3 vco_sync (
    .clk(SYS_CLK), .reset(RESET), .async_in(VCO_DIV_IN), .level(), .rise(vco_rise)
  );

  // Window placement around the reference edge
  always_comb begin
    w_total = win_cycles(ctrl_reg, ring_cfg_reg, duration_reg);
    window.early_cycles = w_total >> 1;
    window.late_cycles = w_total - (w_total >> 1);
    if (ctrl_reg.asym_enable) begin
      window.early_cycles = ctrl_reg.asym_delay_sel ? 14'h0000 : w_total;
      window.late_cycles = ctrl_reg.asym_delay_sel ? w_total : 14'h0000;
    end
  end

  lock_window_meas meas (
    .clk(SYS_CLK), .reset(RESET), .enable(ctrl_reg.lock_detect_enable),
    .ref_rise(ref_rise), .vco_rise(vco_rise), .window(window), .verdict(verdict)
  );

  // Bus channel acceptance
  assign S_AXI_AWREADY = !aw_have_reg && !bvalid_reg;
  assign S_AXI_WREADY = !w_have_reg && !bvalid_reg;
  assign S_AXI_ARREADY = !rvalid_reg;
  assign do_write = aw_have_reg && w_have_reg && !bvalid_reg;
  assign do_read = S_AXI_ARVALID && !rvalid_reg;

  // Lock counting and flag
  always_comb begin
    hits_next = hits_reg;
    lock_next = lock_reg;
    if (!ctrl_reg.lock_detect_enable) begin
      hits_next = 16'h0000;
      lock_next = 1'b0;
    end else if (verdict.miss) begin
      hits_next = 16'h0000;
      lock_next = 1'b0;
    end else if (verdict.hit) begin
      hits_next = (hits_reg >= thresh_reg) ? thresh_reg : hits_reg + 16'h0001;
      lock_next = (hits_next >= thresh_reg) && (hits_next != 16'h0000);
    end
  end

  // Slip prevention: one VCO edge per reference period means matched
  always_comb begin
    vco_per_ref_next = vco_per_ref_reg;
    match_next = match_reg;
    if (vco_rise && vco_per_ref_reg != 2'h3) begin
      vco_per_ref_next = vco_per_ref_reg + 2'h1;
    end
    if (!ctrl_reg.csp_enable) begin
      match_next = 8'h00;
    end else if (ref_rise) begin
      vco_per_ref_next = {1'b0, vco_rise};
      if (vco_per_ref_reg == 2'h1 && match_reg != 8'hFF) begin
        match_next = match_reg + 8'h01;
      end else if (vco_per_ref_reg != 2'h1) begin
        match_next = 8'h00;
      end
    end
    hold_next = ctrl_reg.csp_enable && (match_next < corr_reg);
    up_src_next = hold_next ? 3'h7 : up_gain_reg;
    dn_src_next = hold_next ? 3'h7 : dn_gain_reg;
  end

  // Shared pin: lock flag, serial data during a read
  always_comb begin
    pin_next = SERIAL_READ_DATA;
    oe_n_next = !(SERIAL_READ_ACTIVE || ctrl_reg.lock_flag_pin_enable);
    if (ctrl_reg.lock_flag_pin_enable && !SERIAL_READ_ACTIVE) begin
      pin_next = lock_next;
    end
  end

  // Register file, bus slave and interrupt flags
  always_comb begin
    ctrl_next = ctrl_reg;
    ring_cfg_next = ring_cfg_reg;
    duration_next = duration_reg;
    thresh_next = thresh_reg;
    corr_next = corr_reg;
    up_gain_next = up_gain_reg;
    dn_gain_next = dn_gain_reg;
    up_trim_next = up_trim_reg;
    dn_trim_next = dn_trim_reg;
    irq_stat_next = irq_stat_reg;
    irq_mask_next = irq_mask_reg;
    aw_have_next = aw_have_reg;
    w_have_next = w_have_reg;
    awaddr_next = awaddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bvalid_next = bvalid_reg && !S_AXI_BREADY;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg && !S_AXI_RREADY;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_have_next = 1'b1;
      awaddr_next = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_have_next = 1'b1;
      wdata_next = S_AXI_WDATA;
      wstrb_next = S_AXI_WSTRB;
    end
    if (do_write) begin
      aw_have_next = 1'b0;
      w_have_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = `RESP_OKAY;
      case ({awaddr_reg[7:2], 2'b00})
        `OFS_CTRL: ctrl_next = ctrl_type'(6'(merge(32'(ctrl_reg), wdata_reg, wstrb_reg)));
        `OFS_WINDOW: begin
          ring_cfg_next = 4'(merge(32'(ring_cfg_reg), wdata_reg, wstrb_reg));
          duration_next = 8'(merge({16'h0000, duration_reg, 8'h00}, wdata_reg, wstrb_reg)
                             >> `WIN_DUR_LSB);
        end
        `OFS_THRESH: thresh_next = 16'(merge(32'(thresh_reg), wdata_reg, wstrb_reg));
        `OFS_CSP: corr_next = 8'(merge(32'(corr_reg), wdata_reg, wstrb_reg));
        `OFS_PUMP: begin
          {dn_trim_next, up_trim_next, dn_gain_next[2:0], up_gain_next} =
            {dn_trim_reg, up_trim_reg, dn_gain_reg, up_gain_reg};
          if (wstrb_reg[0]) begin
            up_gain_next = wdata_reg[2:0];
            dn_gain_next = wdata_reg[`PUMP_DN_GAIN_LSB +: 3];
          end
          if (wstrb_reg[1]) begin
            up_trim_next = wdata_reg[`PUMP_UP_TRIM_LSB +: 4];
            dn_trim_next = wdata_reg[`PUMP_DN_TRIM_LSB +: 4];
          end
        end
        `OFS_IRQ_MASK: irq_mask_next = 3'(merge(32'(irq_mask_reg), wdata_reg, wstrb_reg));
        `OFS_STATUS, `OFS_IRQ_STAT: bresp_next = `RESP_OKAY;
        default: bresp_next = `RESP_SLVERR;
      endcase
    end
    if (do_read) begin
      rvalid_next = 1'b1;
      rresp_next = `RESP_OKAY;
      case ({S_AXI_ARADDR[7:2], 2'b00})
        `OFS_CTRL: rdata_next = 32'(ctrl_reg);
        `OFS_WINDOW: rdata_next = {16'h0000, duration_reg, 4'h0, ring_cfg_reg};
        `OFS_THRESH: rdata_next = {16'h0000, thresh_reg};
        `OFS_CSP: rdata_next = {24'h000000, corr_reg};
        `OFS_PUMP: rdata_next = {16'h0000, dn_trim_reg, up_trim_reg, 1'b0, dn_gain_reg,
                                 1'b0, up_gain_reg};
        `OFS_STATUS: rdata_next = {hits_reg, 14'h0000, hold_reg, lock_reg};
        `OFS_IRQ_STAT: begin
          rdata_next = {29'h00000000, irq_stat_reg};
          irq_stat_next = 3'h0;
        end
        `OFS_IRQ_MASK: rdata_next = {29'h00000000, irq_mask_reg};
        default: begin
          rdata_next = 32'h00000000;
          rresp_next = `RESP_SLVERR;
        end
      endcase
    end
    // Events set after the read clear, so they win
    irq_stat_next = irq_stat_next | events;
  end

  assign events = {verdict.miss & ctrl_reg.lock_detect_enable,
                   lock_reg & ~lock_next, ~lock_reg & lock_next};

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      ctrl_reg <= ctrl_type'(`RST_CTRL);
      ring_cfg_reg <= `RST_RING_CFG;
      duration_reg <= `RST_DURATION;
      thresh_reg <= `RST_THRESH;
      corr_reg <= `RST_CORR;
      up_gain_reg <= `RST_PUMP_GAIN;
      dn_gain_reg <= `RST_PUMP_GAIN;
      up_trim_reg <= `RST_PUMP_TRIM;
      dn_trim_reg <= `RST_PUMP_TRIM;
      irq_stat_reg <= 3'h0;
      irq_mask_reg <= 3'h0;
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `RESP_OKAY;
      rvalid_reg <= 1'b0;
      rresp_reg <= `RESP_OKAY;
      rdata_reg <= 32'h00000000;
      hits_reg <= 16'h0000;
      lock_reg <= 1'b0;
      match_reg <= 8'h00;
      vco_per_ref_reg <= 2'h0;
      hold_reg <= 1'b0;
      up_src_reg <= `RST_PUMP_GAIN;
      dn_src_reg <= `RST_PUMP_GAIN;
      pin_reg <= 1'b0;
      oe_n_reg <= 1'b1;
    end else begin
      ctrl_reg <= ctrl_next;
      ring_cfg_reg <= ring_cfg_next;
      duration_reg <= duration_next;
      thresh_reg <= thresh_next;
      corr_reg <= corr_next;
      up_gain_reg <= up_gain_next;
      dn_gain_reg <= dn_gain_next;
      up_trim_reg <= up_trim_next;
      dn_trim_reg <= dn_trim_next;
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
      aw_have_reg <= aw_have_next;
      w_have_reg <= w_have_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
      hits_reg <= hits_next;
      lock_reg <= lock_next;
      match_reg <= match_next;
      vco_per_ref_reg <= vco_per_ref_next;
      hold_reg <= hold_next;
      up_src_reg <= up_src_next;
      dn_src_reg <= dn_src_next;
      pin_reg <= pin_next;
      oe_n_reg <= oe_n_next;
    end
  end

  // Outputs
  assign LOCK_FLAG = lock_reg;
  assign LOCK_OR_SERIAL_OUT_PIN = pin_reg;
  assign LOCK_OR_SERIAL_OUT_OE_N = oe_n_reg;
  assign CSP_GAIN_HOLD = hold_reg;
  assign PUMP_UP_SOURCES = up_src_reg;
  assign PUMP_DOWN_SOURCES = dn_src_reg;
  assign PUMP_UP_TRIM_OUT = up_trim_reg;
  assign PUMP_DOWN_TRIM_OUT = dn_trim_reg;
  assign IRQ = |(irq_stat_reg & irq_mask_reg);
  assign S_AXI_BVALID = bvalid_reg;
  assign S_AXI_BRESP = bresp_reg;
  assign S_AXI_RVALID = rvalid_reg;
  assign S_AXI_RRESP = rresp_reg;
  assign S_AXI_RDATA = rdata_reg;
endmodule // pll_lock_detect_and_pump_ctrl
`default_nettype wire

// ### design/pll_lock_pkg.sv
package pll_lock_pkg;

  // Control bits as software sees them
  typedef struct packed {
    logic lock_flag_pin_enable;
    logic csp_enable;
    logic asym_delay_sel;
    logic asym_enable;
    logic window_from_ring;
    logic lock_detect_enable;
  } ctrl_type;

  // Window shape handed to the measurement unit
  typedef struct packed {
    logic [13:0] early_cycles;
    logic [13:0] late_cycles;
  } window_type;

  // Per-reference-cycle verdict
  typedef struct packed {
    logic hit;
    logic miss;
  } verdict_type;

  typedef enum logic [0:0] {
    WAIT_REF = 1'b0,
    LATE_OPEN = 1'b1
  } win_state_type;

endpackage

// ### verification/pll_edge_source.sv
`timescale 1ns/1ns
`default_nettype none
// Free running divided reference and VCO; VCO tied to reference at an offset when rates match
module pll_edge_source (
  input wire logic clk,
  input wire logic reset,
  input var int per,
  input var int vper,
  input var int off,
  output logic ref_out,
  output logic vco_out
);
  int rcnt;
  int vcnt;
  // Divider counters
  always_ff @(posedge clk) begin
    if (reset) begin
      rcnt <= 0;
      vcnt <= 0;
    end else begin
      rcnt <= (rcnt >= per - 1) ? 0 : rcnt + 1;
      if (vper == per && rcnt >= per - 1) vcnt <= ((per - off) % per + per) % per;
      else vcnt <= (vcnt >= vper - 1) ? 0 : vcnt + 1;
    end
  end
  // Square outputs
  assign ref_out = rcnt < per / 2;
  assign vco_out = vcnt < vper / 2;
endmodule // pll_edge_source
`default_nettype wire

// ### verification/pll_lock_detect_and_pump_ctrl_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "pll_lock_cfg.svh"
module pll_lock_detect_and_pump_ctrl_tb_top;
  logic SYS_CLK = 1'b0;
  logic RESET = 1'b1;
  logic REF_DIV_IN, VCO_DIV_IN, LOCK_OR_SERIAL_OUT_PIN, LOCK_OR_SERIAL_OUT_OE_N;
  logic SERIAL_READ_ACTIVE = 1'b0, SERIAL_READ_DATA = 1'b0;
  logic LOCK_FLAG, CSP_GAIN_HOLD, IRQ;
  logic [2:0] PUMP_UP_SOURCES, PUMP_DOWN_SOURCES;
  logic [3:0] PUMP_UP_TRIM_OUT, PUMP_DOWN_TRIM_OUT, S_AXI_WSTRB = 4'hF;
  logic [7:0] S_AXI_AWADDR = 8'h00, S_AXI_ARADDR = 8'h00;
  logic [31:0] S_AXI_WDATA = 32'h0, S_AXI_RDATA, rd;
  logic S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0;
  logic S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0;
  logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP, rr;
  int per = 40, vper = 40, off = 0, refs = 0, fails = 0, comparisons = 0;

  // Clock, design and edge source
  always #10 SYS_CLK = ~SYS_CLK;
  always @(posedge REF_DIV_IN) refs++;
  pll_lock_detect_and_pump_ctrl i_dut (.*);
  pll_edge_source i_src (.clk(SYS_CLK), .reset(RESET), .per(per), .vper(vper), .off(off),
    .ref_out(REF_DIV_IN), .vco_out(VCO_DIV_IN));

  task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask

  // Write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, tb;
    int n;
    tb = 1'b0;
    n = 0;
    @(posedge SYS_CLK);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    while (!tb && n < 50) begin
      @(negedge SYS_CLK);
      ta = S_AXI_AWVALID && S_AXI_AWREADY;
      tw = S_AXI_WVALID && S_AXI_WREADY;
      tb = S_AXI_BVALID;
      rr = S_AXI_BRESP;
      @(posedge SYS_CLK);
      if (ta) S_AXI_AWVALID <= 1'b0;
      if (tw) S_AXI_WVALID <= 1'b0;
      n++;
    end
    S_AXI_BREADY <= 1'b0;
    chk("write response", {1'b1, er}, {tb, rr});
  endtask

  // Read and compare the masked word
  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] m, e,
                    input logic [1:0] er);
    logic tr, h;
    int n;
    tr = 1'b0;
    n = 0;
    @(posedge SYS_CLK);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    while (!tr && n < 50) begin
      @(negedge SYS_CLK);
      h = S_AXI_ARVALID && S_AXI_ARREADY;
      tr = S_AXI_RVALID;
      rd = S_AXI_RDATA;
      rr = S_AXI_RRESP;
      @(posedge SYS_CLK);
      if (h) S_AXI_ARVALID <= 1'b0;
      n++;
    end
    S_AXI_RREADY <= 1'b0;
    chk(nm, {1'b1, er, e}, {tr, rr, rd & m});
  endtask

  task automatic wt(ref logic s, input logic v, input int lim);
    for (int n = 0; n < lim && s !== v; n++) @(negedge SYS_CLK);
    chk("awaited level", v, s);
  endtask

  task automatic t_regs();
    rc("ctrl", `OFS_CTRL, '1, 32'h0, `RESP_OKAY);
    rc("window", `OFS_WINDOW, '1, 32'h100, `RESP_OKAY);
    rc("thresh", `OFS_THRESH, '1, 32'h3E8, `RESP_OKAY);
    rc("corr", `OFS_CSP, '1, 32'h4, `RESP_OKAY);
    rc("pump", `OFS_PUMP, '1, 32'h22, `RESP_OKAY);
    rc("mask", `OFS_IRQ_MASK, '1, 32'h0, `RESP_OKAY);
    rc("unmapped", 8'h20, '1, 32'h0, `RESP_SLVERR);
    wr(8'h24, 32'h1, `RESP_SLVERR);
    wr(`OFS_STATUS, 32'hFFFF_FFFF, `RESP_OKAY);
    rc("status", `OFS_STATUS, '1, 32'h0, `RESP_OKAY);
  endtask

  task automatic t_pump();
    for (int i = 0; i < 8; i++) begin
      wr(`OFS_PUMP, {16'h0, 4'(15 - i), 4'(2 * i), 1'b0, 3'(7 - i), 1'b0, 3'(i)}, `RESP_OKAY);
      repeat (2) @(negedge SYS_CLK);
      chk("pump gains", {3'(i), 3'(7 - i)}, {PUMP_UP_SOURCES, PUMP_DOWN_SOURCES});
      chk("pump trims", {4'(2 * i), 4'(15 - i)}, {PUMP_UP_TRIM_OUT, PUMP_DOWN_TRIM_OUT});
    end
  endtask

  // Lock with an in-window offset, then lose it with an outside one
  task automatic t_lock(input logic [5:0] c, input int hit, miss);
    int r0;
    off <= hit;
    r0 = refs;
    wr(`OFS_CTRL, {26'h0, c}, `RESP_OKAY);
    wt(LOCK_FLAG, 1'b1, 800);
    chk("edges before lock", 1, refs - r0 >= 3);
    rc("locked status", `OFS_STATUS, 32'hFFFF_0001, 32'h3_0001, `RESP_OKAY);
    off <= miss;
    wt(LOCK_FLAG, 1'b0, 200);
    rc("miss status", `OFS_STATUS, 32'hFFFF_0001, 32'h0, `RESP_OKAY);
    wr(`OFS_CTRL, 32'h0, `RESP_OKAY);
  endtask

  task automatic t_pin();
    rc("irq clear", `OFS_IRQ_STAT, 32'h0, 32'h0, `RESP_OKAY);
    wr(`OFS_IRQ_MASK, 32'h1, `RESP_OKAY);
    off <= 0;
    wr(`OFS_CTRL, 32'h21, `RESP_OKAY);
    wt(LOCK_FLAG, 1'b1, 800);
    @(negedge SYS_CLK);
    chk("pin with lock", 3'b011, {LOCK_OR_SERIAL_OUT_OE_N, LOCK_OR_SERIAL_OUT_PIN, IRQ});
    rc("irq status", `OFS_IRQ_STAT, 32'h1, 32'h1, `RESP_OKAY);
    repeat (2) @(negedge SYS_CLK);
    chk("irq after read", 0, IRQ);
    @(posedge SYS_CLK);
    SERIAL_READ_ACTIVE <= 1'b1;
    repeat (3) @(negedge SYS_CLK);
    chk("pin in read", 0, {LOCK_OR_SERIAL_OUT_OE_N, LOCK_OR_SERIAL_OUT_PIN});
    @(posedge SYS_CLK);
    SERIAL_READ_ACTIVE <= 1'b0;
    repeat (3) @(negedge SYS_CLK);
    chk("pin after read", 1, {LOCK_OR_SERIAL_OUT_OE_N, LOCK_OR_SERIAL_OUT_PIN});
    wr(`OFS_CTRL, 32'h1E, `RESP_OKAY);
    repeat (300) @(negedge SYS_CLK);
    chk("flag while disabled", 0, LOCK_FLAG);
    wr(`OFS_CTRL, 32'h0, `RESP_OKAY);
  endtask

  // Hold while rates differ, release after the programmed matched periods
  task automatic t_csp(input int c);
    int n;
    vper <= 15;
    wr(`OFS_CSP, c, `RESP_OKAY);
    wr(`OFS_CTRL, 32'h10, `RESP_OKAY);
    repeat (200) @(negedge SYS_CLK);
    chk("hold gain", 4'hF, {CSP_GAIN_HOLD, PUMP_DOWN_SOURCES});
    vper <= 40;
    for (n = 0; n < 800 && CSP_GAIN_HOLD === 1'b1; n++) @(negedge SYS_CLK);
    chk("release time", 1, n >= (c - 1) * 40 && n <= (c + 3) * 40);
    wr(`OFS_CTRL, 32'h0, `RESP_OKAY);
  endtask

  task automatic results();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (2) @(posedge SYS_CLK);
    RESET <= 1'b0;
    t_regs();
    t_pump();
    wr(`OFS_THRESH, 32'h3, `RESP_OKAY);
    t_lock(6'h01, 0, 8);
    wr(`OFS_WINDOW, 32'h0800, `RESP_OKAY);
    t_lock(6'h03, 3, 12);
    t_lock(6'h0F, 6, -6);
    t_lock(6'h07, -6, 6);
    t_pin();
    t_csp(2);
    t_csp(8);
    results();
  end

  // Watchdog
  initial begin
    #1_000_000;
    fails++;
    results();
  end
endmodule // pll_lock_detect_and_pump_ctrl_tb_top
`default_nettype wire

// ### verification/pll_lock_monitor.sv
`timescale 1ns/1ns
`default_nettype none
// Port checks for the lock detect and pump control block
module pll_lock_monitor (
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire logic SERIAL_READ_ACTIVE,
  input wire logic SERIAL_READ_DATA,
  input wire logic LOCK_OR_SERIAL_OUT_PIN,
  input wire logic LOCK_OR_SERIAL_OUT_OE_N,
  input wire logic LOCK_FLAG,
  input wire logic CSP_GAIN_HOLD,
  input wire logic [2:0] PUMP_UP_SOURCES,
  input wire logic [2:0] PUMP_DOWN_SOURCES,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0] S_AXI_RRESP,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RESET);

  // Reset leaves flag low, pin released and bus idle
  AST_RESET_STATE: assert property (disable iff (1'b0) RESET |=> !LOCK_FLAG &&
    LOCK_OR_SERIAL_OUT_OE_N && !S_AXI_BVALID && !S_AXI_RVALID)
    else $error("state after reset wrong");
  AST_PIN_READ: assert property (SERIAL_READ_ACTIVE |=>
    !LOCK_OR_SERIAL_OUT_OE_N && LOCK_OR_SERIAL_OUT_PIN == $past(SERIAL_READ_DATA))
    else $error("pin not carrying read data");
  AST_PIN_LOCK: assert property (!SERIAL_READ_ACTIVE && !$past(SERIAL_READ_ACTIVE) &&
    !LOCK_OR_SERIAL_OUT_OE_N |-> LOCK_OR_SERIAL_OUT_PIN == LOCK_FLAG)
    else $error("pin not carrying lock flag");
  AST_CSP_MAX: assert property (CSP_GAIN_HOLD |->
    PUMP_UP_SOURCES == 3'h7 && PUMP_DOWN_SOURCES == 3'h7)
    else $error("gain not at maximum during hold");
  // Bus answers and their holding
  AST_B_LAT: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
    |-> ##[1:2] S_AXI_BVALID) else $error("write answer late");
  AST_B_HOLD: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID &&
    $stable(S_AXI_BRESP)) else $error("write answer dropped");
  AST_R_LAT: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read answer late");
  AST_R_HOLD: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID &&
    $stable(S_AXI_RDATA) && $stable(S_AXI_RRESP)) else $error("read answer dropped");
  AST_AR_BLOCK: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("address taken during answer");
endmodule // pll_lock_monitor

bind pll_lock_detect_and_pump_ctrl pll_lock_monitor i_mon (.SYS_CLK, .RESET,
  .SERIAL_READ_ACTIVE, .SERIAL_READ_DATA, .LOCK_OR_SERIAL_OUT_PIN, .LOCK_OR_SERIAL_OUT_OE_N,
  .LOCK_FLAG, .CSP_GAIN_HOLD, .PUMP_UP_SOURCES, .PUMP_DOWN_SOURCES, .S_AXI_AWVALID,
  .S_AXI_AWREADY, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY,
  .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY);
`default_nettype wire
